// [design/ebc_alu.sv]
`timescale 1ns/1ps
module ebc_alu
	import ebc_pkg::*;
(
	// Operation and current status
	input  ebc_op_t     op,
	input  logic [7:0]  flags_in,
	// Operands
	input  logic [7:0]  a,
	input  logic [7:0]  b,
	input  logic [15:0] wa,
	// Results
	output logic [7:0]  res,
	output logic [15:0] wres,
	output logic        write_res,
	output logic        write_word,
	output logic [7:0]  flags_out
);
	logic        add_cin;
	logic        sub_cin;
	logic        negate;
	logic        is_compare;
	logic [7:0]  sub_a;
	logic [7:0]  sub_b;
	logic [8:0]  add9;
	logic [4:0]  add_nib;
	logic [8:0]  sub9;
	logic [4:0]  sub_nib;
	logic        add_ovf;
	logic        sub_ovf;
	logic [16:0] wsum;
	logic [16:0] wdif;
	logic        upd_zn;

	assign add_cin    = (op == OP_ADD_CARRY) & flags_in[FLAG_C];
	assign sub_cin    = (op inside {OP_DIFF_WITH_CARRY, OP_DIFF_CARRY_IMM,
		OP_COMPARE_WITH_CARRY}) & flags_in[FLAG_C]; // RL4
	assign is_compare = op inside {OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMM};
	assign negate     = op == OP_ARITH_INVERT;
	assign sub_a      = negate ? BYTE_ZERO : a; // RL6
	assign sub_b      = negate ? a : b;
	// Nine-bit sums wrap the byte and keep carry or borrow on top
	assign add9    = {1'h0, a} + {1'h0, b} + {8'h00, add_cin}; // RL25
	assign add_nib = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, add_cin};
	assign sub9    = {1'h0, sub_a} - {1'h0, sub_b} - {8'h00, sub_cin}; // RL25
	assign sub_nib = {1'h0, sub_a[3:0]} - {1'h0, sub_b[3:0]} - {4'h0, sub_cin};
	assign add_ovf = ~(a[7] ^ b[7]) & (a[7] ^ add9[7]);
	assign sub_ovf = (sub_a[7] ^ sub_b[7]) & (sub_a[7] ^ sub9[7]);
	assign wsum    = {1'h0, wa} + {9'h000, b};
	assign wdif    = {1'h0, wa} - {9'h000, b};

	always_comb begin
		res        = a;
		wres       = wa;
		write_res  = 1'h0;
		write_word = 1'h0;
		upd_zn     = 1'h0;
		flags_out  = flags_in; // RL24
		case (op)
			OP_ADD, OP_ADD_CARRY: begin
				res                = add9[7:0]; // RL1
				write_res          = 1'h1;
				upd_zn             = 1'h1;
				flags_out[FLAG_C]  = add9[8];
				flags_out[FLAG_H]  = add_nib[4];
				flags_out[FLAG_V]  = add_ovf;
			end
			OP_SUB, OP_DIFF_IMM, OP_DIFF_WITH_CARRY, OP_DIFF_CARRY_IMM, OP_ARITH_INVERT,
			OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMM: begin
				res                = sub9[7:0]; // RL3
				write_res          = ~is_compare; // RL14
				upd_zn             = 1'h1;
				flags_out[FLAG_C]  = sub9[8];
				flags_out[FLAG_H]  = sub_nib[4];
				flags_out[FLAG_V]  = sub_ovf;
			end
			OP_AND, OP_CONJ_IMM, OP_OR, OP_DISJ_IMM, OP_EXCLUSIVE_DISJ,
			OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_SIGN_TEST, OP_ZERO_FILL: begin
				if (op inside {OP_AND, OP_CONJ_IMM}) begin
					res = a & b; // RL5
				end else if (op inside {OP_OR, OP_DISJ_IMM, OP_SET_MASK_BITS}) begin
					res = a | b; // RL7
				end else if (op == OP_EXCLUSIVE_DISJ) begin
					res = a ^ b;
				end else if (op == OP_CLEAR_MASK_BITS) begin
					res = a & (BYTE_ONES - b); // RL7
				end else if (op == OP_ZERO_FILL) begin
					res = a ^ a; // RL8
				end else begin
					res = a & a; // RL8
				end
				write_res         = 1'h1;
				upd_zn            = 1'h1;
				flags_out[FLAG_V] = 1'h0;
			end
			OP_BIT_INVERT: begin
				res               = BYTE_ONES - a; // RL6
				write_res         = 1'h1;
				upd_zn            = 1'h1;
				flags_out[FLAG_C] = 1'h1;
				flags_out[FLAG_V] = 1'h0;
			end
			OP_INC, OP_DEC: begin
				res               = (op == OP_INC) ? a + BYTE_ONE : a - BYTE_ONE; // RL8
				write_res         = 1'h1;
				upd_zn            = 1'h1;
				flags_out[FLAG_V] = res == ((op == OP_INC) ? INC_OVF_VALUE : DEC_OVF_VALUE);
			end
			OP_ONES_FILL: begin
				res       = BYTE_ONES; // RL8
				write_res = 1'h1;
			end
			OP_SHIFT_LEFT_LOGICAL: begin
				res               = {a[6:0], 1'h0}; // RL21
				write_res         = 1'h1;
				upd_zn            = 1'h1;
				flags_out[FLAG_C] = a[7];
				flags_out[FLAG_V] = a[7] ^ a[6];
			end
			OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
				wres              = (op == OP_WORD_PLUS_IMM) ? wsum[15:0] : wdif[15:0]; // RL2
				write_word        = 1'h1;
				flags_out[FLAG_C] = (op == OP_WORD_PLUS_IMM) ? wsum[16] : wdif[16];
				flags_out[FLAG_V] = (op == OP_WORD_PLUS_IMM) ? ~wa[15] & wsum[15]
					: wa[15] & ~wdif[15];
				flags_out[FLAG_N] = wres[15];
				flags_out[FLAG_Z] = wres == 16'h0000;
				flags_out[FLAG_S] = wres[15] ^ flags_out[FLAG_V];
			end
			default: begin
			end
		endcase
		if (upd_zn) begin
			flags_out[FLAG_Z] = res == BYTE_ZERO;
			flags_out[FLAG_N] = res[7];
		end
	end

endmodule

// [design/ebc_core.sv]
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RL1 - Add, with optional carry, one clock
// RL2 - Word immediate add/subtract, two clocks
// RL3 - Subtract register or constant, one clock
// RL4 - Subtract-with-carry also subtracts carry flag
// RL5 - AND/OR/XOR update only Z, N, V
// RL6 - Invert and negate with their flags
// RL7 - Set/clear mask bits update Z, N, V
// RL8 - Inc/dec/test/clear flags; ones fill none
// RL9 - Relative jump PC plus offset plus one
// RL10 - Pointer jump two, absolute three clocks
// RL11 - Calls four clocks, direct call five
// RL12 - Returns five clocks; interrupt exit sets I
// RL13 - Skip when equal, one to three clocks
// RL14 - Compares set flags, store nothing
// RL15 - Skip on register bit clear/set
// RL16 - Skip on I/O bit clear/set
// RL17 - Generic flag branch, one/two clocks
// RL18 - Named branches test single flags
// RL19 - Signed branches use N xor V
// RL20 - I/O bit set/clear, two clocks
// RL21 - Shift left, zero into bit 0
// RL22 - I/O bit ops only below 32
// RL23 - I/O bit ops rewrite whole register
// RL24 - Unaffected flags keep their values
// RL25 - Byte results wrap, signed overflow
module ebc_core
	import ebc_pkg::*;
(
	// Clock and reset
	input  logic        core_clk,
	input  logic        srst,
	// Issue port
	input  logic        start,
	input  ebc_op_t     op,
	input  logic [7:0]  rd_val,
	input  logic [7:0]  rd_hi_val,
	input  logic [7:0]  rr_val,
	input  logic [7:0]  imm,
	input  logic [2:0]  bit_sel,
	input  logic [11:0] offset,
	input  logic [5:0]  io_addr,
	input  logic [7:0]  io_rdata,
	input  logic [15:0] z_ptr,
	input  logic [15:0] target,
	input  logic [15:0] stack_top,
	input  logic        next_two_word,
	output logic        ready,
	// Completion and write-back
	output logic        done,
	output logic        rd_we,
	output logic        rd_word,
	output logic [7:0]  rd_wdata,
	output logic [7:0]  rd_hi_wdata,
	output logic        io_we,
	output logic [5:0]  io_waddr,
	output logic [7:0]  io_wdata,
	output logic        stack_push,
	output logic        stack_pop,
	output logic [15:0] stack_wdata,
	// Architectural state
	output logic [15:0] pc,
	output logic [7:0]  status_flags,
	output logic        fault,
	// Register port
	input  logic [3:0]  reg_addr,
	input  logic [7:0]  reg_wdata,
	input  logic        reg_wr,
	input  logic        reg_rd,
	output logic [7:0]  reg_rdata
);
	logic [2:0]  cnt;
	logic        accept;
	logic        fire;
	logic [7:0]  alu_b;
	logic [7:0]  alu_res;
	logic [15:0] alu_wres;
	logic        alu_wr;
	logic        alu_ww;
	logic [7:0]  alu_flags;
	logic [15:0] off_ext;
	logic [15:0] pc_step;
	logic [15:0] pc_rel;
	logic [15:0] pc_skip;
	logic [2:0]  cyc_skip;
	logic        io_ok;
	logic        io_skip;
	logic        skip_hit;
	logic        named_br;
	logic        is_branch;
	logic        br_on_set;
	logic [2:0]  br_idx;
	logic        br_take;
	logic [7:0]  bit_mask;
	logic [7:0]  io_set_val;
	logic [7:0]  io_clr_val;
	// Decoded next values
	logic [15:0] next_pc;
	logic [2:0]  next_cyc;
	logic        next_push;
	logic        next_pop;
	logic [15:0] next_ret;
	logic        next_io_we;
	logic [7:0]  next_io_wdata;
	logic        next_fault;
	logic [7:0]  next_flags;
	logic [7:0]  next_lo;
	// Held values for multi-clock operations
	logic [15:0] pend_pc;
	logic        pend_push;
	logic        pend_pop;
	logic [15:0] pend_ret;
	logic        pend_io_we;
	logic [7:0]  pend_io_wdata;
	logic [5:0]  pend_io_addr;
	logic        pend_fault;
	logic [7:0]  pend_flags;
	logic [7:0]  pend_lo;
	logic [7:0]  pend_hi;
	logic        pend_wr;
	logic        pend_ww;
	// Commit sources
	logic [15:0] c_pc;
	logic        c_push;
	logic        c_pop;
	logic [15:0] c_ret;
	logic        c_io_we;
	logic [7:0]  c_io_wdata;
	logic [5:0]  c_io_addr;
	logic        c_fault;
	logic [7:0]  c_flags;
	logic [7:0]  c_lo;
	logic [7:0]  c_hi;
	logic        c_wr;
	logic        c_ww;
	// Register port decode
	logic        wr_flags;
	logic        wr_pc_lo;
	logic        wr_pc_hi;
	logic        clr_fault;
	logic [7:0]  rd_mux;

	assign ready  = cnt == 3'h0;
	assign accept = start & ready;

	// Immediate forms take the constant in place of the second register
	assign alu_b = (op inside {OP_DIFF_IMM, OP_DIFF_CARRY_IMM, OP_CONJ_IMM, OP_DISJ_IMM,
		OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_COMPARE_IMM, OP_WORD_PLUS_IMM,
		OP_WORD_MINUS_IMM}) ? imm : rr_val;

	ebc_alu u_alu (
		.op         (op),
		.flags_in   (status_flags),
		.a          (rd_val),
		.b          (alu_b),
		.wa         ({rd_hi_val, rd_val}),
		.res        (alu_res),
		.wres       (alu_wres),
		.write_res  (alu_wr),
		.write_word (alu_ww),
		.flags_out  (alu_flags)
	);

	// Program counter targets
	assign off_ext  = {{4{offset[11]}}, offset};
	assign pc_step  = pc + PC_STEP_ONE;
	assign pc_rel   = pc + off_ext + PC_STEP_ONE; // RL9
	assign pc_skip  = next_two_word ? pc + PC_STEP_THREE : pc + PC_STEP_TWO; // RL13
	assign cyc_skip = next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;

	// Skip conditions
	assign io_ok    = io_addr < IO_BIT_LIMIT; // RL22
	assign io_skip  = op inside {OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH};
	assign skip_hit = ((op == OP_SKIP_IF_EQUAL) & (rd_val == rr_val)) // RL13
		| ((op == OP_SKIP_REG_BIT_LOW) & ~rr_val[bit_sel]) // RL15
		| ((op == OP_SKIP_REG_BIT_HIGH) & rr_val[bit_sel])
		| (io_skip & io_ok & (io_rdata[bit_sel] == (op == OP_SKIP_IO_BIT_HIGH))); // RL16

	// Branch conditions
	assign named_br  = op inside {[OP_BR_EQUAL:OP_BR_INT_DISABLED]};
	assign is_branch = named_br | (op inside {[OP_FLAG_SET_BRANCH:OP_SIGNED_LT_BRANCH]});
	assign br_on_set = op inside {OP_FLAG_SET_BRANCH, OP_BR_EQUAL, OP_BR_CARRY_SET,
		OP_BR_LOWER, OP_BR_MINUS, OP_BR_HALF_SET, OP_BR_T_SET, OP_BR_OVF_SET,
		OP_BR_INT_ENABLED}; // RL18

	always_comb begin
		br_idx = bit_sel; // RL17
		case (op)
			OP_BR_EQUAL, OP_BR_NOT_EQUAL: br_idx = FLAG_Z; // RL18
			OP_BR_CARRY_SET, OP_BR_LOWER, OP_BR_CARRY_CLEAR, OP_BR_SAME_HIGHER: br_idx = FLAG_C;
			OP_BR_MINUS, OP_BR_PLUS: br_idx = FLAG_N;
			OP_BR_HALF_SET, OP_BR_HALF_CLEAR: br_idx = FLAG_H;
			OP_BR_T_SET, OP_BR_T_CLEAR: br_idx = FLAG_T;
			OP_BR_OVF_SET, OP_BR_OVF_CLEAR: br_idx = FLAG_V;
			OP_BR_INT_ENABLED, OP_BR_INT_DISABLED: br_idx = FLAG_I;
			default: br_idx = bit_sel;
		endcase
	end

	assign br_take = (op == OP_SIGNED_GE_BRANCH) ? ~(status_flags[FLAG_N] ^ status_flags[FLAG_V])
		: (op == OP_SIGNED_LT_BRANCH) ? status_flags[FLAG_N] ^ status_flags[FLAG_V] // RL19
		: status_flags[br_idx] == br_on_set; // RL17

	// Whole-register rewrite with one bit forced
	assign bit_mask   = BYTE_ONE << bit_sel;
	assign io_set_val = io_rdata | bit_mask; // RL23
	assign io_clr_val = io_rdata & ~bit_mask; // RL23

	assign next_flags = (op == OP_INTERRUPT_EXIT) ? status_flags | FLAG_I_MASK : alu_flags; // RL12
	assign next_lo    = alu_ww ? alu_wres[7:0] : alu_res;

	always_comb begin
		next_pc       = pc_step;
		next_cyc      = CYC_SINGLE;
		next_push     = 1'h0;
		next_pop      = 1'h0;
		next_ret      = pc_step;
		next_io_we    = 1'h0;
		next_io_wdata = io_set_val;
		next_fault    = 1'h0;
		case (op)
			OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: next_cyc = CYC_WORD; // RL2
			OP_PC_RELATIVE_JUMP: begin
				next_pc  = pc_rel; // RL9
				next_cyc = CYC_REL_JUMP;
			end
			OP_POINTER_JUMP: begin
				next_pc  = z_ptr; // RL10
				next_cyc = CYC_PTR_JUMP;
			end
			OP_ABSOLUTE_JUMP: begin
				next_pc  = target; // RL10
				next_cyc = CYC_ABS_JUMP;
			end
			OP_RELATIVE_CALL, OP_POINTER_CALL: begin
				next_pc   = (op == OP_RELATIVE_CALL) ? pc_rel : z_ptr; // RL11
				next_cyc  = (op == OP_RELATIVE_CALL) ? CYC_REL_CALL : CYC_PTR_CALL;
				next_push = 1'h1;
			end
			OP_DIRECT_CALL: begin
				next_pc   = target; // RL11
				next_cyc  = CYC_DIR_CALL;
				next_push = 1'h1;
				next_ret  = pc + PC_STEP_TWO;
			end
			OP_SUB_RETURN, OP_INTERRUPT_EXIT: begin
				next_pc  = stack_top; // RL12
				next_cyc = CYC_RETURN;
				next_pop = 1'h1;
			end
			OP_SKIP_IF_EQUAL, OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH,
			OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH: begin
				next_fault = io_skip & ~io_ok; // RL22
				if (skip_hit) begin
					next_pc  = pc_skip; // RL15
					next_cyc = cyc_skip;
				end
			end
			OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
				next_io_wdata = (op == OP_IO_BIT_SET) ? io_set_val : io_clr_val; // RL20
				next_io_we    = io_ok; // RL22
				next_fault    = ~io_ok;
				next_cyc      = io_ok ? CYC_IO_BIT : CYC_SINGLE;
			end
			default: begin
				if (is_branch & br_take) begin
					next_pc  = pc_rel; // RL17
					next_cyc = CYC_BR_TAKEN;
				end
			end
		endcase
	end

	// Single-clock operations commit straight from the decode
	assign fire       = (accept & (next_cyc == CYC_SINGLE)) | (cnt == 3'h1);
	assign c_pc       = accept ? next_pc : pend_pc;
	assign c_push     = accept ? next_push : pend_push;
	assign c_pop      = accept ? next_pop : pend_pop;
	assign c_ret      = accept ? next_ret : pend_ret;
	assign c_io_we    = accept ? next_io_we : pend_io_we;
	assign c_io_wdata = accept ? next_io_wdata : pend_io_wdata;
	assign c_io_addr  = accept ? io_addr : pend_io_addr;
	assign c_fault    = accept ? next_fault : pend_fault;
	assign c_flags    = accept ? next_flags : pend_flags;
	assign c_lo       = accept ? next_lo : pend_lo;
	assign c_hi       = accept ? alu_wres[15:8] : pend_hi;
	assign c_wr       = accept ? alu_wr | alu_ww : pend_wr;
	assign c_ww       = accept ? alu_ww : pend_ww;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt <= 3'h0;
		end else if (accept) begin
			cnt <= next_cyc - CYC_SINGLE;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (accept) begin
			pend_pc       <= next_pc;
			pend_push     <= next_push;
			pend_pop      <= next_pop;
			pend_ret      <= next_ret;
			pend_io_we    <= next_io_we;
			pend_io_wdata <= next_io_wdata;
			pend_io_addr  <= io_addr;
			pend_fault    <= next_fault;
			pend_flags    <= next_flags;
			pend_lo       <= next_lo;
			pend_hi       <= alu_wres[15:8];
			pend_wr       <= alu_wr | alu_ww;
			pend_ww       <= alu_ww;
		end
	end

	// Write-back pulses and their data
	always_ff @(posedge core_clk) begin
		if (srst) begin
			done        <= 1'h0;
			rd_we       <= 1'h0;
			rd_word     <= 1'h0;
			rd_wdata    <= BYTE_ZERO;
			rd_hi_wdata <= BYTE_ZERO;
			io_we       <= 1'h0;
			io_waddr    <= 6'h00;
			io_wdata    <= BYTE_ZERO;
			stack_push  <= 1'h0;
			stack_pop   <= 1'h0;
			stack_wdata <= PC_RESET;
		end else begin
			done       <= fire;
			rd_we      <= fire & c_wr;
			io_we      <= fire & c_io_we;
			stack_push <= fire & c_push;
			stack_pop  <= fire & c_pop;
			if (fire) begin
				rd_word     <= c_ww;
				rd_wdata    <= c_lo;
				rd_hi_wdata <= c_hi;
				io_waddr    <= c_io_addr;
				io_wdata    <= c_io_wdata;
				stack_wdata <= c_ret;
			end
		end
	end

	// Register port; an instruction commit wins over a software write
	assign wr_flags  = reg_wr & (reg_addr == REG_FLAGS);
	assign wr_pc_lo  = reg_wr & (reg_addr == REG_PC_LO);
	assign wr_pc_hi  = reg_wr & (reg_addr == REG_PC_HI);
	assign clr_fault = reg_wr & (reg_addr == REG_FAULT) & reg_wdata[0];
	assign rd_mux    = (reg_addr == REG_FLAGS) ? status_flags
		: (reg_addr == REG_PC_LO) ? pc[7:0]
		: (reg_addr == REG_PC_HI) ? pc[15:8]
		: (reg_addr == REG_FAULT) ? {7'h00, fault}
		: BYTE_ZERO;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pc           <= PC_RESET;
			status_flags <= FLAGS_RESET;
		end else if (fire) begin
			pc           <= c_pc;
			status_flags <= c_flags; // RL24
		end else begin
			if (wr_flags) begin
				status_flags <= reg_wdata;
			end
			if (wr_pc_lo) begin
				pc[7:0] <= reg_wdata;
			end
			if (wr_pc_hi) begin
				pc[15:8] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fault     <= 1'h0;
			reg_rdata <= BYTE_ZERO;
		end else begin
			fault     <= (fire & c_fault) | (fault & ~clr_fault); // RL22
			reg_rdata <= reg_rd ? rd_mux : BYTE_ZERO;
		end
	end

endmodule

// [design/ebc_pkg.sv]
package ebc_pkg;

	// Operations presented on the issue port, one per instruction
	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM,
		OP_SUB, OP_DIFF_IMM, OP_DIFF_WITH_CARRY, OP_DIFF_CARRY_IMM,
		OP_AND, OP_CONJ_IMM, OP_OR, OP_DISJ_IMM, OP_EXCLUSIVE_DISJ,
		OP_BIT_INVERT, OP_ARITH_INVERT, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
		OP_INC, OP_DEC, OP_ZERO_SIGN_TEST, OP_ZERO_FILL, OP_ONES_FILL,
		OP_SHIFT_LEFT_LOGICAL,
		OP_PC_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABSOLUTE_JUMP,
		OP_RELATIVE_CALL, OP_POINTER_CALL, OP_DIRECT_CALL,
		OP_SUB_RETURN, OP_INTERRUPT_EXIT,
		OP_SKIP_IF_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMM,
		OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH,
		OP_FLAG_SET_BRANCH, OP_FLAG_CLEAR_BRANCH, OP_SIGNED_GE_BRANCH, OP_SIGNED_LT_BRANCH,
		OP_BR_EQUAL, OP_BR_NOT_EQUAL, OP_BR_CARRY_SET, OP_BR_LOWER,
		OP_BR_CARRY_CLEAR, OP_BR_SAME_HIGHER, OP_BR_MINUS, OP_BR_PLUS,
		OP_BR_HALF_SET, OP_BR_HALF_CLEAR, OP_BR_T_SET, OP_BR_T_CLEAR,
		OP_BR_OVF_SET, OP_BR_OVF_CLEAR, OP_BR_INT_ENABLED, OP_BR_INT_DISABLED,
		OP_IO_BIT_SET, OP_IO_BIT_CLEAR
	} ebc_op_t;

	// Bit positions in status_flags
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	localparam logic [7:0] FLAG_I_MASK = 8'h80;

	// Reset values
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET    = 16'h0000;

	// Byte constants
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [7:0] BYTE_ONE      = 8'h01;
	localparam logic [7:0] BYTE_ONES     = 8'hFF;
	localparam logic [7:0] INC_OVF_VALUE = 8'h80;
	localparam logic [7:0] DEC_OVF_VALUE = 8'h7F;

	// Program counter steps
	localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
	localparam logic [15:0] PC_STEP_THREE = 16'h0003;

	// Clock counts per operation
	localparam logic [2:0] CYC_SINGLE    = 3'h1;
	localparam logic [2:0] CYC_WORD      = 3'h2;
	localparam logic [2:0] CYC_REL_JUMP  = 3'h2;
	localparam logic [2:0] CYC_PTR_JUMP  = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP  = 3'h3;
	localparam logic [2:0] CYC_REL_CALL  = 3'h4;
	localparam logic [2:0] CYC_PTR_CALL  = 3'h4;
	localparam logic [2:0] CYC_DIR_CALL  = 3'h5;
	localparam logic [2:0] CYC_RETURN    = 3'h5;
	localparam logic [2:0] CYC_BR_TAKEN  = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE  = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO  = 3'h3;
	localparam logic [2:0] CYC_IO_BIT    = 3'h2;

	// Bit-addressable I/O range ends here
	localparam logic [5:0] IO_BIT_LIMIT = 6'h20;

	// Register port map
	localparam logic [3:0] REG_FLAGS = 4'h0;
	localparam logic [3:0] REG_PC_LO = 4'h1;
	localparam logic [3:0] REG_PC_HI = 4'h2;
	localparam logic [3:0] REG_FAULT = 4'h3;

endpackage

// [test/ebc_core_assertions.sv]
`timescale 1ns/1ps
module ebc_core_chk
	import ebc_pkg::*;
(
	// Clock and reset
	input logic        core_clk,
	input logic        srst,
	// Issue side
	input logic        start,
	input logic        ready,
	input ebc_op_t     op,
	input logic [2:0]  bit_sel,
	input logic [11:0] offset,
	input logic [5:0]  io_addr,
	input logic [7:0]  io_rdata,
	input logic [15:0] target,
	// Results
	input logic        done,
	input logic        io_we,
	input logic [7:0]  io_wdata,
	input logic        stack_push,
	input logic [15:0] pc,
	input logic [7:0]  status_flags,
	input logic        fault
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	wire        go = start && ready;
	wire [15:0] off_x = {{4{offset[11]}}, offset};
	sequence s_wait1; !done; endsequence
	sequence s_wait2; !done ##1 !done; endsequence
	sequence s_wait4; s_wait2 ##1 s_wait2; endsequence
	a_add_one: assert property (go && op == OP_ADD |=> done)
		else $error("add not done in one clock");
	a_word_two: assert property (go && op == OP_WORD_PLUS_IMM |=> s_wait1 ##1 done)
		else $error("word add not two clocks");
	a_fill_flags: assert property (go && op == OP_ONES_FILL |=> $stable(status_flags))
		else $error("ones fill changed flags");
	a_rel_jump: assert property (go && op == OP_PC_RELATIVE_JUMP |=> s_wait1 ##1
		(done && pc == $past(pc, 2) + $past(off_x, 2) + 16'h0001))
		else $error("relative jump wrong");
	a_abs_jump: assert property (go && op == OP_ABSOLUTE_JUMP |=> s_wait2 ##1
		(done && pc == $past(target, 3)))
		else $error("absolute jump wrong");
	a_dir_call: assert property (go && op == OP_DIRECT_CALL |=> s_wait4 ##1
		(done && stack_push && pc == $past(target, 5)))
		else $error("direct call wrong");
	a_io_set: assert property (go && op == OP_IO_BIT_SET && io_addr < IO_BIT_LIMIT
		|=> s_wait1 ##1 (done && io_we
		&& io_wdata == ($past(io_rdata, 2) | (8'h01 << $past(bit_sel, 2)))))
		else $error("io bit set wrong");
	a_io_refuse: assert property (go && op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR}
		&& io_addr >= IO_BIT_LIMIT |=> done && !io_we && fault)
		else $error("high io address not refused");
	a_lt_branch: assert property (go && op == OP_SIGNED_LT_BRANCH
		&& status_flags[FLAG_N] == status_flags[FLAG_V] |=> done && pc == $past(pc) + 16'h0001)
		else $error("signed branch taken wrongly");
endmodule
bind ebc_core ebc_core_chk u_chk (.*);

// [test/ebc_io_model.sv]
`timescale 1ns/1ps
module ebc_io_model
	import ebc_pkg::*;
(
	// Clock
	input logic       core_clk,
	// Access from the core
	input logic [5:0] io_addr,
	input logic       io_we,
	input logic [5:0] io_waddr,
	input logic [7:0] io_wdata,
	output logic [7:0] io_rdata
);
	logic [7:0] mem [64] = '{default: 8'h81};
	assign io_rdata = mem[io_addr];
	// Bit 7 is a flag that clears on every write, whatever value is written
	always @(posedge core_clk) begin
		if (io_we)
			mem[io_waddr] <= io_wdata & 8'h7F;
	end
endmodule

// [test/test_ebc_core.sv]
`timescale 1ns/1ps
module test_ebc_core;
	import ebc_pkg::*;
	logic        core_clk, srst, start, next_two_word, reg_wr, reg_rd;
	ebc_op_t     op;
	logic [7:0]  rd_val, rd_hi_val, rr_val, imm, io_rdata, reg_wdata, reg_rdata;
	logic [7:0]  rd_wdata, rd_hi_wdata, io_wdata, status_flags;
	logic [2:0]  bit_sel;
	logic [11:0] offset;
	logic [5:0]  io_addr, io_waddr;
	logic [3:0]  reg_addr;
	logic [15:0] z_ptr, target, stack_top, pc, stack_wdata, exp_pc;
	logic        ready, done, rd_we, rd_word, io_we, stack_push, stack_pop, fault;
	int          fail_count, cmp_count, n, i;
	ebc_op_t     aop[9] = '{OP_ADD, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_DIFF_WITH_CARRY, OP_AND,
		OP_BIT_INVERT, OP_ONES_FILL, OP_SHIFT_LEFT_LOGICAL};
	logic [7:0]  ad[9] = '{8'h0F, 8'h80, 8'h01, 8'h00, 8'h10, 8'hF0, 8'h00, 8'h00, 8'h40};
	logic [7:0]  ar[9] = '{8'h01, 8'h80, 8'h01, 8'h01, 8'h01, 8'h0F, 8'h00, 8'h00, 8'h00};
	logic [7:0]  ares[9] = '{8'h10, 8'h00, 8'h03, 8'hFF, 8'h0E, 8'h00, 8'hFF, 8'hFF, 8'h80};
	logic [7:0]  afl[9] = '{8'h20, 8'h0B, 8'h00, 8'h25, 8'h20, 8'h22, 8'h25, 8'h25, 8'h2C};
	int          bfl[16] = '{1, 1, 0, 0, 0, 0, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
	logic [15:0] bpol = 16'h554D;
	ebc_op_t     jop[8] = '{OP_ABSOLUTE_JUMP, OP_PC_RELATIVE_JUMP, OP_POINTER_JUMP,
		OP_RELATIVE_CALL, OP_POINTER_CALL, OP_DIRECT_CALL, OP_SUB_RETURN, OP_INTERRUPT_EXIT};
	int          jcy[8] = '{3, 2, 2, 4, 4, 5, 5, 5};
	logic [15:0] jpc[8] = '{16'h1234, 16'h1245, 16'h0300, 16'h0311, 16'h0300, 16'h1234,
		16'h0050, 16'h0050};
	ebc_core u_dut (.*);
	ebc_io_model u_io (.core_clk(core_clk), .io_addr(io_addr), .io_we(io_we),
		.io_waddr(io_waddr), .io_wdata(io_wdata), .io_rdata(io_rdata));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task summarize;
		$display("mismatches %0d compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Issue one operation, count clocks until done
	task run(input ebc_op_t o, input logic [7:0] d, input logic [7:0] r);
		@(posedge core_clk);
		op <= o;
		rd_val <= d;
		rr_val <= r;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n == 8) begin
			fail_count++;
			summarize();
		end
	endtask
	task br(input ebc_op_t o, input logic tk);
		run(o, 8'h00, 8'h00);
		exp_pc = tk ? exp_pc - 16'h0001 : exp_pc + 16'h0001;
		chk(16'(n), tk ? 16'h0002 : 16'h0001);
		chk(pc, exp_pc);
	endtask
	task sk(input ebc_op_t o, input logic [7:0] d, input logic [7:0] r, input int step);
		run(o, d, r);
		exp_pc = exp_pc + 16'(step);
		chk(16'(n), 16'(step));
		chk(pc, exp_pc);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	initial begin
		{start, next_two_word, reg_wr, reg_rd, rd_val, rd_hi_val, rr_val, imm} = '0;
		{bit_sel, offset, io_addr, reg_addr, reg_wdata, z_ptr, target, stack_top} = '0;
		op = OP_ADD;
		fail_count = 0;
		cmp_count = 0;
		srst = 1'b1;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		rd(REG_FLAGS, FLAGS_RESET);
		for (i = 0; i < 9; i++) begin
			run(aop[i], ad[i], ar[i]);
			chk(16'(n), 16'h0001);
			chk(rd_wdata, ares[i]);
			chk(status_flags, afl[i]);
		end
		imm <= 8'h01;
		run(OP_WORD_PLUS_IMM, 8'hFF, 8'h00);
		chk(16'(n), 16'h0002);
		chk({rd_hi_wdata, rd_wdata}, 16'h0100);
		chk(status_flags, 8'h20);
		run(OP_WORD_MINUS_IMM, 8'h00, 8'h00);
		chk({rd_hi_wdata, rd_wdata}, 16'hFFFF);
		chk(status_flags, 8'h35);
		exp_pc = 16'h000B;
		offset <= 12'hFFE;
		for (i = 0; i < 16; i++) begin
			wr(REG_FLAGS, 8'h01 << bfl[i]);
			br(ebc_op_t'(int'(OP_BR_EQUAL) + i), bpol[i]);
		end
		for (i = 0; i < 8; i++) begin
			bit_sel <= 3'(i);
			wr(REG_FLAGS, 8'h01 << i);
			br(OP_FLAG_SET_BRANCH, 1'b1);
			br(OP_FLAG_CLEAR_BRANCH, 1'b0);
		end
		wr(REG_FLAGS, 8'h0C);
		br(OP_SIGNED_GE_BRANCH, 1'b1);
		br(OP_SIGNED_LT_BRANCH, 1'b0);
		wr(REG_FLAGS, 8'h04);
		br(OP_SIGNED_GE_BRANCH, 1'b0);
		br(OP_SIGNED_LT_BRANCH, 1'b1);
		z_ptr <= 16'h0300;
		target <= 16'h1234;
		stack_top <= 16'h0050;
		offset <= 12'h010;
		for (i = 0; i < 8; i++) begin
			run(jop[i], 8'h00, 8'h00);
			chk(16'(n), 16'(jcy[i]));
			chk(pc, jpc[i]);
			chk({15'h0000, stack_push}, 16'(i > 2 && i < 6));
		end
		chk(status_flags, 8'h84);
		exp_pc = 16'h0050;
		next_two_word <= 1'b1;
		sk(OP_SKIP_IF_EQUAL, 8'h5A, 8'h5A, 3);
		sk(OP_SKIP_IF_EQUAL, 8'h5A, 8'h5B, 1);
		next_two_word <= 1'b0;
		bit_sel <= 3'h3;
		io_addr <= 6'h05;
		sk(OP_SKIP_REG_BIT_HIGH, 8'h00, 8'h08, 2);
		sk(OP_SKIP_REG_BIT_LOW, 8'h00, 8'h08, 1);
		sk(OP_SKIP_IO_BIT_LOW, 8'h00, 8'h00, 2);
		sk(OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 1);
		bit_sel <= 3'h2;
		run(OP_IO_BIT_SET, 8'h00, 8'h00);
		chk(16'(n), 16'h0002);
		chk(io_wdata, 8'h85);
		@(posedge core_clk);
		#1;
		chk(u_io.mem[5], 8'h05);
		bit_sel <= 3'h0;
		run(OP_IO_BIT_CLEAR, 8'h00, 8'h00);
		chk(io_wdata, 8'h04);
		io_addr <= 6'h20;
		run(OP_IO_BIT_SET, 8'h00, 8'h00);
		chk(16'(n), 16'h0001);
		chk({15'h0000, fault}, 16'h0001);
		rd(REG_FAULT, 8'h01);
		wr(REG_FAULT, 8'h01);
		rd(REG_FAULT, 8'h00);
		rd(4'hF, 8'h00);
		summarize();
	end
endmodule
